// File: sim/octal_registered_bus_transceiver_tb.sv
// self-checking bench for the octal registered bus transceiver
`timescale 1ns/100ps
module octal_registered_bus_transceiver_tb;
	logic clk_i = 0;
	logic reset_i = 1;
	logic oe_n = 1, dir = 0, a_to_b_source_select = 0, b_to_a_source_select = 0, cab = 0, cba = 0, rdy = 0;
	logic [7:0] pa = 0, pb = 0, a_o, b_o, a_w, b_w, areg, breg;
	logic a_oe, b_oe, valid, room, drop;
	logic [17:0] ld;
	logic [31:0] r;
	logic [17:0] q[$];
	int fails = 0, checks = 0, cyc = 0, drops = 0, exp_drops = 0;
	integer seed = 32'hd742_50ec;

	otx_transceiver i_dut (.clk_i(clk_i), .reset_i(reset_i),
		.output_enable_n_i(oe_n), .drive_side_select_i(dir),
		.a_to_b_source_select_i(a_to_b_source_select), .b_to_a_source_select_i(b_to_a_source_select),
		.a_side_capture_clock_i(cab), .b_side_capture_clock_i(cba),
		.port_a_lines_i(a_w), .port_a_lines_o(a_o),
		.port_a_lines_oe_o(a_oe), .port_b_lines_i(b_w),
		.port_b_lines_o(b_o), .port_b_lines_oe_o(b_oe),
		.capture_log_data_o(ld), .capture_log_valid_o(valid),
		.capture_log_ready_i(rdy), .capture_log_room_o(room),
		.capture_log_drop_o(drop));

	otx_bus_partner i_far (.a_val_i(pa), .b_val_i(pb), .a_dev_i(a_o),
		.a_oe_i(a_oe), .b_dev_i(b_o), .b_oe_i(b_oe), .a_wire_o(a_w),
		.b_wire_o(b_w));

	always #20 clk_i = ~clk_i;

	task automatic chk(input string what, input logic [17:0] e,
		input logic [17:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic chk_port(input string what, input logic [7:0] e,
		input logic [7:0] g);
		chk(what, {10'h000, e}, {10'h000, g});
	endtask : chk_port

	task automatic chk_log(input string what, input logic [17:0] e,
		input logic [17:0] g);
		chk(what, e, g);
	endtask : chk_log

	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wait_n

	// a hang stops here instead of running on forever
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			give_verdict();
		end
	end

	always @(posedge clk_i)
		if (!reset_i)
		begin
			if (drop === 1'b1)
				drops++;
			if (valid === 1'b1 && rdy === 1'b1)
			begin
				if (q.size() == 0)
					chk("log_extra", 18'h0_0000, {17'h0, valid});
				else
					chk_log("log", q[0], ld);
				if (q.size() != 0)
					void'(q.pop_front());
			end
		end

	task automatic check_ports();
		chk_port("a_oe", {7'h0, !oe_n && !dir}, {7'h0, a_oe});
		chk_port("b_oe", {7'h0, !oe_n && dir}, {7'h0, b_oe});
		if (!oe_n && !dir)
			chk_port("a_data", b_to_a_source_select ? breg : pb, a_o);
		if (!oe_n && dir)
			chk_port("b_data", a_to_b_source_select ? areg : pa, b_o);
	endtask : check_ports

	// ready stays low across a capture so the model queue count is exact
	task automatic capture(input logic ca, input logic cb);
		logic [7:0] wa;
		logic [7:0] wb;
		wa = (!oe_n && !dir) ? (b_to_a_source_select ? breg : pb) : pa;
		wb = (!oe_n && dir) ? (a_to_b_source_select ? areg : pa) : pb;
		rdy = 0;
		cab = ca;
		cba = cb;
		wait_n(3);
		cab = 0;
		cba = 0;
		if (ca | cb)
		begin
			if (q.size() == 2)
				exp_drops++;
			else
				q.push_back({cb, ca, wb, wa});
		end
		if (ca)
			areg = wa;
		if (cb)
			breg = wb;
		wait_n(6);
		chk("room", {17'h0, q.size() != 2}, {17'h0, room});
	endtask : capture

	initial
	begin
		wait_n(5);
		reset_i = 0;
		wait_n(1);
		pa = 8'h5a;
		pb = 8'ha5;
		wait_n(6);
		capture(1, 1);
		rdy = 1;
		wait_n(4);
		capture(1, 0);
		capture(0, 1);
		capture(1, 1);
		rdy = 1;
		wait_n(6);
		for (int i = 0; i < 200; i++)
		begin
			r = $random(seed);
			{oe_n, dir, a_to_b_source_select, b_to_a_source_select} = r[3:0];
			pa = r[11:4];
			pb = r[19:12];
			rdy = r[22];
			wait_n(6);
			check_ports();
			capture(r[20], r[21]);
			check_ports();
		end
		rdy = 1;
		wait_n(6);
		chk("drops", exp_drops[17:0], drops[17:0]);
		chk("log_left", 18'h0_0000, {17'h0, q.size() != 0});
		give_verdict();
	end
endmodule : octal_registered_bus_transceiver_tb

// File: sim/otx_bus_partner.sv
// far-side bus logic on both transceiver ports
`timescale 1ns/100ps
module otx_bus_partner (
	input wire logic [7:0] a_val_i, // value the far side offers on A
	input wire logic [7:0] b_val_i, // value the far side offers on B
	input wire logic [7:0] a_dev_i, // device drive value on A
	input wire logic a_oe_i, // device drives A
	input wire logic [7:0] b_dev_i, // device drive value on B
	input wire logic b_oe_i, // device drives B
	output logic [7:0] a_wire_o, // resolved level on A
	output logic [7:0] b_wire_o // resolved level on B
);
	// far side lets go of a port while the device drives it
	assign a_wire_o = a_oe_i ? a_dev_i : a_val_i;
	assign b_wire_o = b_oe_i ? b_dev_i : b_val_i;
endmodule : otx_bus_partner

// File: src/otx_capture_buf.sv
// two-entry capture buffer; output word comes straight from a register
`timescale 1ns/100ps
`include "otx_params.svh"
module otx_capture_buf #(
	parameter int WIDTH = 18
) (
	input wire logic clk_i, // system clock
	input wire logic reset_i, // async reset, active high
	otx_stream_if.sink fill, // filling side
	otx_stream_if.source drain // draining side
);
	initial
	begin
		if (`OTX_BUF_ENTRIES != 2 || WIDTH < 1)
			$error("otx_capture_buf: unsupported size");
	end

	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic [WIDTH-1:0] head_reg;
	logic [WIDTH-1:0] head_next;
	logic [WIDTH-1:0] spare_reg;
	logic [WIDTH-1:0] spare_next;
	logic push;
	logic pop;

	assign fill.ready = (count_reg != 2'h2);
	assign drain.valid = (count_reg != 2'h0);
	assign drain.data = head_reg;
	assign push = fill.valid & fill.ready;
	assign pop = drain.valid & drain.ready;

	always_comb
	begin
		count_next = count_reg;
		head_next = head_reg;
		spare_next = spare_reg;
		case ({push, pop})
			2'h3:
			begin
				if (count_reg == 2'h1)
					head_next = fill.data;
				else
				begin
					head_next = spare_reg;
					spare_next = fill.data;
				end
			end
			2'h1:
			begin
				head_next = spare_reg;
				count_next = count_reg - 2'h1;
			end
			2'h2:
			begin
				if (count_reg == 2'h0)
					head_next = fill.data;
				else
					spare_next = fill.data;
				count_next = count_reg + 2'h1;
			end
			default:
			begin
				count_next = count_reg;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			count_reg <= 2'h0;
			head_reg <= '0;
			spare_reg <= '0;
		end
		else
		begin
			count_reg <= count_next;
			head_reg <= head_next;
			spare_reg <= spare_next;
		end
	end

	a_buf_no_overrun : assert property (@(posedge clk_i) disable iff (reset_i)
		(count_reg == 2'h2 && !pop) |=> count_reg == 2'h2)
		else $error("capture buffer lost its fill level");

endmodule : otx_capture_buf

// File: src/otx_params.svh
// constants for the octal registered bus transceiver
`ifndef OTX_PARAMS_SVH
`define OTX_PARAMS_SVH

`define OTX_DATA_W 8
`define OTX_SYNC_STAGES 2
`define OTX_BUF_ENTRIES 2
`define OTX_CLK_PERIOD_NS 40
`define OTX_CTRL_W 6
`define OTX_CTRL_OE_N 5
`define OTX_CTRL_DIR 4
`define OTX_CTRL_SAB 3
`define OTX_CTRL_SBA 2
`define OTX_CTRL_CAB 1
`define OTX_CTRL_CBA 0
`define OTX_LOG_FLAGS 2
`define OTX_LOG_A_FLAG 0
`define OTX_LOG_B_FLAG 1

`endif

// File: src/otx_pkg.sv
// types for the octal registered bus transceiver
package otx_pkg;

	typedef enum logic [1:0]
	{
		OTX_ISOLATE = 2'h0,
		OTX_DRIVE_A = 2'h1,
		OTX_DRIVE_B = 2'h2
	} otx_drive_t;

endpackage : otx_pkg

// File: src/otx_stream_if.sv
// valid/ready word stream between the transceiver and its capture buffer
`timescale 1ns/100ps
interface otx_stream_if #(parameter int WIDTH = 18);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : otx_stream_if

// File: src/otx_transceiver.sv
// octal registered bus transceiver with capture log
//
// Overview of operation
// - capture clock edges load each side register
// - capture ignores output enable and direction
// - enable high floats both ports, registers still load
// - drive A with live B data
// - drive A with stored B data
// - drive B with live A data
// - drive B with stored A data
// - input port may load either or both registers
// - never drive both ports at once
`timescale 1ns/100ps
`include "otx_params.svh"
module otx_transceiver #(
	parameter int DATA_W = `OTX_DATA_W,
	parameter int SYNC_STAGES = `OTX_SYNC_STAGES
) (
	input wire logic clk_i, // system clock, 25 MHz
	input wire logic reset_i, // async reset, active high
	input wire logic output_enable_n_i, // pin: outputs enabled when low
	input wire logic drive_side_select_i, // pin: high drives B, low drives A
	input wire logic a_to_b_source_select_i, // pin: high = stored A to B
	input wire logic b_to_a_source_select_i, // pin: high = stored B to A
	input wire logic a_side_capture_clock_i, // pin: loads A register on rise
	input wire logic b_side_capture_clock_i, // pin: loads B register on rise
	input wire logic [DATA_W-1:0] port_a_lines_i, // level seen on A
	output logic [DATA_W-1:0] port_a_lines_o, // value driven on A
	output logic port_a_lines_oe_o, // high while A is driven
	input wire logic [DATA_W-1:0] port_b_lines_i, // level seen on B
	output logic [DATA_W-1:0] port_b_lines_o, // value driven on B
	output logic port_b_lines_oe_o, // high while B is driven
	output logic [2*DATA_W+1:0] capture_log_data_o, // logged capture word
	output logic capture_log_valid_o, // log word available
	input wire logic capture_log_ready_i, // receiver takes log word
	output logic capture_log_room_o, // buffer can take a capture
	output logic capture_log_drop_o // pulse: capture not logged
);
	localparam int IN_W = `OTX_CTRL_W + 2 * DATA_W;
	localparam int LOG_W = 2 * DATA_W + `OTX_LOG_FLAGS;

	initial
	begin
		if (DATA_W < 1)
			$error("otx_transceiver: DATA_W must be at least 1");
		if (SYNC_STAGES < 2)
			$error("otx_transceiver: SYNC_STAGES must be at least 2");
	end

	// decodes which port the device may drive; used by the drive logic only, not by the checks
	function automatic otx_pkg::otx_drive_t drive_mode(
		input logic oe_n,
		input logic dir
	);
		otx_pkg::otx_drive_t m;
		m = otx_pkg::OTX_ISOLATE;
		if (!oe_n)
			m = dir ? otx_pkg::OTX_DRIVE_B : otx_pkg::OTX_DRIVE_A;
		return m;
	endfunction : drive_mode

	// every pin crosses two flops before use; data and clocks share
	// the same chain so a captured word lines up with its edge
	logic [IN_W-1:0] pins_raw;
	logic [IN_W-1:0] sync_reg [SYNC_STAGES];
	logic [IN_W-1:0] sync_next [SYNC_STAGES];
	logic [IN_W-1:0] pins_s;

	assign pins_raw = {output_enable_n_i, drive_side_select_i,
		a_to_b_source_select_i, b_to_a_source_select_i,
		a_side_capture_clock_i, b_side_capture_clock_i,
		port_a_lines_i, port_b_lines_i};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_STAGES; gi++)
		begin : g_sync
			if (gi == 0)
			begin : g_first
				always_comb
				begin
					sync_next[gi] = pins_raw;
				end
			end
			else
			begin : g_rest
				always_comb
				begin
					sync_next[gi] = sync_reg[gi-1];
				end
			end
			always_ff @(posedge clk_i or posedge reset_i)
			begin
				if (reset_i)
					sync_reg[gi] <= '0;
				else
					sync_reg[gi] <= sync_next[gi];
			end
		end
	endgenerate

	assign pins_s = sync_reg[SYNC_STAGES-1];

	logic [`OTX_CTRL_W-1:0] ctrl_s;
	logic oe_n_s;
	logic dir_s;
	logic sab_s;
	logic sba_s;
	logic cab_s;
	logic cba_s;
	logic [DATA_W-1:0] a_s;
	logic [DATA_W-1:0] b_s;

	assign ctrl_s = pins_s[IN_W-1 -: `OTX_CTRL_W];
	assign oe_n_s = ctrl_s[`OTX_CTRL_OE_N];
	assign dir_s = ctrl_s[`OTX_CTRL_DIR];
	assign sab_s = ctrl_s[`OTX_CTRL_SAB];
	assign sba_s = ctrl_s[`OTX_CTRL_SBA];
	assign cab_s = ctrl_s[`OTX_CTRL_CAB];
	assign cba_s = ctrl_s[`OTX_CTRL_CBA];
	assign a_s = pins_s[2*DATA_W-1 -: DATA_W];
	assign b_s = pins_s[DATA_W-1:0];

	// capture registers
	logic cab_prev_reg;
	logic cab_prev_next;
	logic cba_prev_reg;
	logic cba_prev_next;
	logic [DATA_W-1:0] a_store_reg;
	logic [DATA_W-1:0] a_store_next;
	logic [DATA_W-1:0] b_store_reg;
	logic [DATA_W-1:0] b_store_next;
	logic a_rise;
	logic b_rise;

	assign a_rise = cab_s & ~cab_prev_reg;
	assign b_rise = cba_s & ~cba_prev_reg;

	// no term of the enable or direction reaches the capture path
	always_comb
	begin
		cab_prev_next = cab_s;
		cba_prev_next = cba_s;
		a_store_next = a_rise ? a_s : a_store_reg;
		b_store_next = b_rise ? b_s : b_store_reg;
	end

	// the device has no store reset; zero here only gives simulation a
	// known start and must not be relied on by users
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cab_prev_reg <= 1'h0;
			cba_prev_reg <= 1'h0;
			a_store_reg <= '0;
			b_store_reg <= '0;
		end
		else
		begin
			cab_prev_reg <= cab_prev_next;
			cba_prev_reg <= cba_prev_next;
			a_store_reg <= a_store_next;
			b_store_reg <= b_store_next;
		end
	end

	// drive side; both enables come from one decode so they never overlap
	otx_pkg::otx_drive_t mode;
	logic [DATA_W-1:0] a_out_reg;
	logic [DATA_W-1:0] a_out_next;
	logic [DATA_W-1:0] b_out_reg;
	logic [DATA_W-1:0] b_out_next;
	logic a_oe_reg;
	logic a_oe_next;
	logic b_oe_reg;
	logic b_oe_next;

	assign mode = drive_mode(oe_n_s, dir_s);

	always_comb
	begin
		a_oe_next = 1'h0;
		b_oe_next = 1'h0;
		case (mode)
			otx_pkg::OTX_DRIVE_A:
			begin
				a_oe_next = 1'h1;
			end
			otx_pkg::OTX_DRIVE_B:
			begin
				b_oe_next = 1'h1;
			end
			default:
			begin
				a_oe_next = 1'h0;
				b_oe_next = 1'h0;
			end
		endcase
		a_out_next = sba_s ? b_store_reg : b_s;
		b_out_next = sab_s ? a_store_reg : a_s;
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			a_out_reg <= '0;
			b_out_reg <= '0;
			a_oe_reg <= 1'h0;
			b_oe_reg <= 1'h0;
		end
		else
		begin
			a_out_reg <= a_out_next;
			b_out_reg <= b_out_next;
			a_oe_reg <= a_oe_next;
			b_oe_reg <= b_oe_next;
		end
	end

	assign port_a_lines_o = a_out_reg;
	assign port_a_lines_oe_o = a_oe_reg;
	assign port_b_lines_o = b_out_reg;
	assign port_b_lines_oe_o = b_oe_reg;

	// capture log: a full buffer cannot stall the pins, so the word is
	// dropped and flagged rather than held back
	otx_stream_if #(.WIDTH(LOG_W)) log_fill ();
	otx_stream_if #(.WIDTH(LOG_W)) log_drain ();
	logic drop_reg;
	logic drop_next;

	assign log_fill.valid = a_rise | b_rise;
	assign log_fill.data = {b_rise, a_rise, b_s, a_s};

	always_comb
	begin
		drop_next = log_fill.valid & ~log_fill.ready;
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			drop_reg <= 1'h0;
		else
			drop_reg <= drop_next;
	end

	otx_capture_buf #(.WIDTH(LOG_W)) u_log (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.fill(log_fill.sink),
		.drain(log_drain.source)
	);

	assign log_drain.ready = capture_log_ready_i;
	assign capture_log_data_o = log_drain.data;
	assign capture_log_valid_o = log_drain.valid;
	assign capture_log_room_o = log_fill.ready;
	assign capture_log_drop_o = drop_reg;

	// checks
	sequence s_ab_stored_steady;
		(!oe_n_s && dir_s && sab_s) [*2];
	endsequence

	sequence s_ba_stored_steady;
		(!oe_n_s && !dir_s && sba_s) [*2];
	endsequence

	a_a_capture : assert property (
		@(posedge clk_i) disable iff (reset_i)
		a_rise |=> a_store_reg == $past(a_s))
		else $error("A register missed its capture");

	a_b_capture : assert property (
		@(posedge clk_i) disable iff (reset_i)
		b_rise |=> b_store_reg == $past(b_s))
		else $error("B register missed its capture");

	a_capture_isolated : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(oe_n_s && b_rise) |=> (b_store_reg == $past(b_s)) && !b_oe_reg)
		else $error("capture blocked while outputs disabled");

	a_store_hold : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(!a_rise && !b_rise) |=> $stable(a_store_reg) && $stable(b_store_reg))
		else $error("register changed without a capture edge");

	a_ports_float : assert property (
		@(posedge clk_i) disable iff (reset_i)
		oe_n_s |=> !port_a_lines_oe_o && !port_b_lines_oe_o)
		else $error("port driven while output enable high");

	a_live_b_to_a : assert property (
		@(posedge clk_i) disable iff (reset_i) (!oe_n_s && !dir_s && !sba_s)
		|=> port_a_lines_oe_o && port_a_lines_o == $past(b_s))
		else $error("live B data not on port A");

	a_stored_b_to_a : assert property (
		@(posedge clk_i) disable iff (reset_i) (!oe_n_s && !dir_s && sba_s)
		|=> port_a_lines_oe_o && port_a_lines_o == $past(b_store_reg))
		else $error("stored B data not on port A");

	a_live_a_to_b : assert property (
		@(posedge clk_i) disable iff (reset_i) (!oe_n_s && dir_s && !sab_s)
		|=> port_b_lines_oe_o && port_b_lines_o == $past(a_s))
		else $error("live A data not on port B");

	a_stored_a_to_b : assert property (
		@(posedge clk_i) disable iff (reset_i) (!oe_n_s && dir_s && sab_s)
		|=> port_b_lines_oe_o && port_b_lines_o == $past(a_store_reg))
		else $error("stored A data not on port B");

	a_both_capture : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(a_rise && b_rise) |=> a_store_reg == $past(a_s)
		&& b_store_reg == $past(b_s))
		else $error("simultaneous capture lost a word");

	a_one_driver : assert property (
		@(posedge clk_i) disable iff (reset_i)
		!(port_a_lines_oe_o && port_b_lines_oe_o))
		else $error("both ports driven at once");

	a_stored_follow_ab : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(a_rise ##1 s_ab_stored_steady) |-> port_b_lines_o == $past(a_s, 2))
		else $error("port B did not follow new A capture");

	a_stored_follow_ba : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(b_rise ##1 s_ba_stored_steady) |-> port_a_lines_o == $past(b_s, 2))
		else $error("port A did not follow new B capture");

endmodule : otx_transceiver
